// ### hw/asb_serial_ctrl.sv
/*
 * asb_serial_ctrl: addressable serial bus interface control for an instrument.
 * assumes rxd_pin is asynchronous; own_address and local_key come from logic on clk.
 */
`timescale 1ns/1ps
module asb_serial_ctrl #(
   parameter int unsigned BIT_CYCLES = asb_pkg::BIT_CYCLES,
   parameter int unsigned FIFO_DEPTH = asb_pkg::RESP_FIFO_DEPTH
) (
   // clock and reset
   input  wire logic        clk,
   input  wire logic        reset,
   // serial pins
   input  wire logic        rxd_pin,
   output logic             txd_pin,
   // configuration and front panel
   input  wire logic [4:0]  own_address,
   input  wire logic        local_key,
   // received commands
   output asb_pkg::asb_cmd_t cmd,
   output logic             cmd_valid,
   output logic             device_clear,
   // responses from the instrument
   input  wire logic [7:0]  resp_data,
   input  wire logic        resp_valid,
   output logic             resp_ready,
   // interface state
   output asb_pkg::asb_state_t state,
   output logic             remote_indicator_lamp,
   output logic             keypad_lockout
);
   localparam int unsigned CB = asb_pkg::CNT_BITS;
   localparam logic [CB-1:0] BIT_LAST  = CB'(BIT_CYCLES - 1);
   localparam logic [CB-1:0] HALF_LAST = CB'(BIT_CYCLES / 2 - 1);

   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} asb_rx_state_t;
   typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} asb_tx_state_t;
   typedef enum logic       {P_CODE, P_ADDR} asb_parse_state_t;

   // bit timer expiry
   function automatic logic tick(input logic [CB-1:0] c);
      tick = (c == '0);
   endfunction : tick

   // upper-case fold of a seven-bit character
   function automatic logic [7:0] fold_case(input logic [7:0] c);
      fold_case = (c >= asb_pkg::ASCII_LOWER_A && c <= asb_pkg::ASCII_LOWER_Z) ?
                  (c & ~asb_pkg::ASCII_CASE_BIT) : c;
   endfunction : fold_case

   // receive pin synchroniser
   logic [2:0] rx_sync_q;
   logic       rx_line_q;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rx_sync_q <= {3{asb_pkg::RST_LINE_IDLE}};
         rx_line_q <= asb_pkg::RST_LINE_IDLE;
      end else begin
         rx_sync_q <= {rx_sync_q[1:0], rxd_pin};
         if (rx_sync_q[1] == rx_sync_q[2]) rx_line_q <= rx_sync_q[2];
      end
   end

   // receiver
   asb_rx_state_t rx_st_q;
   logic [CB-1:0] rx_cnt_q;
   logic [2:0]    rx_bit_q;
   logic [7:0]    rx_shift_q;
   logic          rx_strobe_q;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rx_st_q     <= RX_IDLE;
         rx_cnt_q    <= '0;
         rx_bit_q    <= '0;
         rx_shift_q  <= '0;
         rx_strobe_q <= 1'b0;
      end else begin
         rx_strobe_q <= 1'b0;
         rx_cnt_q    <= tick(rx_cnt_q) ? BIT_LAST : rx_cnt_q - 1'b1;
         case (rx_st_q)
            RX_IDLE: begin
               rx_cnt_q <= HALF_LAST;
               if (!rx_line_q) rx_st_q <= RX_START;
            end
            RX_START: begin
               if (tick(rx_cnt_q)) rx_st_q <= rx_line_q ? RX_IDLE : RX_DATA;
            end
            RX_DATA: begin
               if (tick(rx_cnt_q)) begin
                  rx_shift_q <= {rx_line_q, rx_shift_q[7:1]};
                  rx_bit_q   <= rx_bit_q + 1'b1;
                  if (rx_bit_q == 3'h7) rx_st_q <= RX_STOP;
               end
            end
            RX_STOP: begin
               if (tick(rx_cnt_q)) begin
                  rx_strobe_q <= rx_line_q;
                  rx_st_q     <= RX_IDLE;
               end
            end
            default: rx_st_q <= RX_IDLE;
         endcase
      end
   end

   // received character decode
   logic             locked_q;
   logic             addressable_q;
   logic             listen_q;
   logic             talk_q;
   logic             remote_q;
   logic             paused_q;
   logic             ack_pend_q;
   logic             addr_talk_q;
   asb_parse_state_t parse_q;

   wire [7:0] rx_char   = locked_q ? rx_shift_q : {1'b0, rx_shift_q[6:0]};
   wire       is_ctrl   = !locked_q && (rx_char < asb_pkg::CODE_CTRL_LIMIT);
   wire       addr_hit  = (rx_char[4:0] == own_address);
   wire       listening = !addressable_q || listen_q;
   wire       talk_ok   = locked_q || !addressable_q || talk_q;
   wire       c_set     = is_ctrl && rx_char == asb_pkg::CODE_SET_ADDR;
   wire       c_unaddr  = is_ctrl && rx_char == asb_pkg::CODE_UNADDR;
   wire       c_lock    = is_ctrl && rx_char == asb_pkg::CODE_LOCK;
   wire       c_lf      = is_ctrl && rx_char == asb_pkg::CODE_LF;
   wire       c_xon     = is_ctrl && rx_char == asb_pkg::CODE_XON;
   wire       c_xoff    = is_ctrl && rx_char == asb_pkg::CODE_XOFF;
   wire       c_listen  = is_ctrl && rx_char == asb_pkg::CODE_LISTEN;
   wire       c_talk    = is_ctrl && rx_char == asb_pkg::CODE_TALK;
   wire       c_clear   = is_ctrl && rx_char == asb_pkg::CODE_CLEAR;
   wire       in_addr   = rx_strobe_q && parse_q == P_ADDR;
   wire       in_code   = rx_strobe_q && parse_q == P_CODE;
   wire       deliver   = in_code && (locked_q || (listening && (c_lf || !is_ctrl)));

   // transmit side signals
   asb_tx_state_t tx_st_q;
   logic          fifo_out_valid;
   logic [7:0]    fifo_out_data;
   wire           tx_idle  = (tx_st_q == TX_IDLE);
   wire           tx_ack   = tx_idle && ack_pend_q;
   wire           tx_pop   = tx_idle && !ack_pend_q && talk_ok && fifo_out_valid &&
                             (locked_q || !paused_q);
   wire           resp_end = tx_pop && fifo_out_data == asb_pkg::CODE_LF;

   // mode, address and remote state
   logic             locked_d;
   logic             addressable_d;
   logic             listen_d;
   logic             talk_d;
   logic             paused_d;
   logic             ack_set;
   logic             addr_talk_d;
   asb_parse_state_t parse_d;

   always_comb begin
      locked_d      = locked_q;
      addressable_d = addressable_q;
      listen_d      = listen_q;
      talk_d        = talk_q;
      paused_d      = paused_q;
      ack_set       = 1'b0;
      addr_talk_d   = addr_talk_q;
      parse_d       = parse_q;
      if (resp_end && addressable_q) talk_d = 1'b0;
      if (in_addr) begin
         parse_d = P_CODE;
         if (addr_talk_q) begin
            talk_d = addr_hit && fifo_out_valid;
         end else begin
            listen_d = addr_hit;
            ack_set  = addr_hit;
         end
      end else if (in_code && is_ctrl) begin
         if (c_set && !addressable_q) begin
            addressable_d = 1'b1;
            listen_d      = 1'b0;
            talk_d        = 1'b0;
         end
         if (c_lock) begin
            locked_d      = 1'b1;
            addressable_d = 1'b0;
            listen_d      = 1'b0;
            talk_d        = 1'b0;
            paused_d      = 1'b0;
         end
         if (addressable_q && (c_unaddr || c_clear)) begin
            listen_d = 1'b0;
            talk_d   = 1'b0;
         end
         if (addressable_q && c_listen) begin
            talk_d      = 1'b0;
            addr_talk_d = 1'b0;
            parse_d     = P_ADDR;
         end
         if (addressable_q && c_talk) begin
            listen_d    = 1'b0;
            addr_talk_d = 1'b1;
            parse_d     = P_ADDR;
         end
         if (c_xoff) paused_d = 1'b1;
         if (c_xon)  paused_d = 1'b0;
      end
   end

   wire remote_set = deliver || (in_addr && addr_hit);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         locked_q      <= asb_pkg::RST_LOCKED;
         addressable_q <= asb_pkg::RST_ADDRESSABLE;
         listen_q      <= 1'b0;
         talk_q        <= 1'b0;
         paused_q      <= 1'b0;
         ack_pend_q    <= 1'b0;
         addr_talk_q   <= 1'b0;
         parse_q       <= P_CODE;
         remote_q      <= asb_pkg::RST_REMOTE;
      end else begin
         locked_q      <= locked_d;
         addressable_q <= addressable_d;
         listen_q      <= listen_d;
         talk_q        <= talk_d;
         paused_q      <= paused_d;
         ack_pend_q    <= ack_set || (ack_pend_q && !tx_ack);
         addr_talk_q   <= addr_talk_d;
         parse_q       <= parse_d;
         remote_q      <= remote_set || (remote_q && !local_key);
      end
   end

   // command output
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cmd          <= '0;
         cmd_valid    <= 1'b0;
         device_clear <= 1'b0;
      end else begin
         cmd_valid    <= deliver;
         device_clear <= in_code && c_clear && addressable_q;
         if (deliver) begin
            cmd.data <= locked_q ? rx_char : fold_case(rx_char);
            cmd.term <= c_lf;
         end
      end
   end

   // response buffer
   asb_fifo #(
      .WIDTH (asb_pkg::CHAR_BITS),
      .DEPTH (FIFO_DEPTH)
   ) u_resp_fifo (
      .clk       (clk),
      .reset     (reset),
      .in_valid  (resp_valid),
      .in_ready  (resp_ready),
      .in_data   (resp_data),
      .out_valid (fifo_out_valid),
      .out_ready (tx_pop),
      .out_data  (fifo_out_data)
   );

   // transmitter
   logic [CB-1:0] tx_cnt_q;
   logic [2:0]    tx_bit_q;
   logic [7:0]    tx_shift_q;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         tx_st_q    <= TX_IDLE;
         tx_cnt_q   <= '0;
         tx_bit_q   <= '0;
         tx_shift_q <= '0;
         txd_pin    <= asb_pkg::RST_LINE_IDLE;
      end else begin
         tx_cnt_q <= tick(tx_cnt_q) ? BIT_LAST : tx_cnt_q - 1'b1;
         case (tx_st_q)
            TX_IDLE: begin
               tx_cnt_q <= BIT_LAST;
               txd_pin  <= 1'b1;
               if (tx_ack || tx_pop) begin
                  tx_shift_q <= tx_ack ? asb_pkg::CODE_ACK : fifo_out_data;
                  txd_pin    <= 1'b0;
                  tx_st_q    <= TX_START;
               end
            end
            TX_START: begin
               if (tick(tx_cnt_q)) begin
                  txd_pin    <= tx_shift_q[0];
                  tx_shift_q <= {1'b0, tx_shift_q[7:1]};
                  tx_bit_q   <= '0;
                  tx_st_q    <= TX_DATA;
               end
            end
            TX_DATA: begin
               if (tick(tx_cnt_q)) begin
                  tx_bit_q <= tx_bit_q + 1'b1;
                  if (tx_bit_q == 3'h7) begin
                     txd_pin <= 1'b1;
                     tx_st_q <= TX_STOP;
                  end else begin
                     txd_pin    <= tx_shift_q[0];
                     tx_shift_q <= {1'b0, tx_shift_q[7:1]};
                  end
               end
            end
            TX_STOP: begin
               if (tick(tx_cnt_q)) tx_st_q <= TX_IDLE;
            end
            default: tx_st_q <= TX_IDLE;
         endcase
      end
   end

   // status outputs
   assign state.locked          = locked_q;
   assign state.addressable     = addressable_q;
   assign state.listen          = listen_q;
   assign state.talk            = talk_q;
   assign state.remote          = remote_q;
   assign state.paused          = paused_q;
   assign remote_indicator_lamp = remote_q;
   assign keypad_lockout        = remote_q;

endmodule : asb_serial_ctrl

// ### hw/asb_pkg.sv
/*
 * asb_pkg: constants and carrier types for the addressable serial bus control block.
 * assumes a 100 MHz instrument clock and a fixed 8N1 character frame.
 */
package asb_pkg;

   // clock and serial timing
   localparam int unsigned CLK_FREQ_HZ     = 100000000;
   localparam int unsigned BAUD_RATE       = 9600;
   localparam int unsigned BIT_CYCLES      = CLK_FREQ_HZ / BAUD_RATE;

   // character frame and address
   localparam int unsigned CHAR_BITS       = 8;
   localparam int unsigned ADDR_BITS       = 5;
   localparam int unsigned RESP_FIFO_DEPTH = 8;
   localparam int unsigned CNT_BITS        = 16;

   // interface control codes
   localparam logic [7:0] CODE_SET_ADDR    = 8'h02;
   localparam logic [7:0] CODE_UNADDR      = 8'h03;
   localparam logic [7:0] CODE_LOCK        = 8'h04;
   localparam logic [7:0] CODE_ACK         = 8'h06;
   localparam logic [7:0] CODE_LF          = 8'h0A;
   localparam logic [7:0] CODE_CR          = 8'h0D;
   localparam logic [7:0] CODE_XON         = 8'h11;
   localparam logic [7:0] CODE_LISTEN      = 8'h12;
   localparam logic [7:0] CODE_XOFF        = 8'h13;
   localparam logic [7:0] CODE_TALK        = 8'h14;
   localparam logic [7:0] CODE_CLEAR       = 8'h18;
   localparam logic [7:0] CODE_CTRL_LIMIT  = 8'h20;
   localparam logic [7:0] ASCII_LOWER_A    = 8'h61;
   localparam logic [7:0] ASCII_LOWER_Z    = 8'h7A;
   localparam logic [7:0] ASCII_CASE_BIT   = 8'h20;

   // reset values
   localparam logic       RST_LOCKED       = 1'b0;
   localparam logic       RST_ADDRESSABLE  = 1'b0;
   localparam logic       RST_REMOTE       = 1'b0;
   localparam logic       RST_LINE_IDLE    = 1'b1;

   // received character handed to the command parser
   typedef struct packed {
      logic [7:0] data;
      logic       term;
   } asb_cmd_t;

   // interface state seen by the instrument
   typedef struct packed {
      logic locked;
      logic addressable;
      logic listen;
      logic talk;
      logic remote;
      logic paused;
   } asb_state_t;

endpackage : asb_pkg

// ### hw/asb_fifo.sv
/*
 * asb_fifo: synchronous first-in first-out buffer with valid/ready on both sides.
 * assumes one clock; writer and reader handshake on the same edge.
 */
`timescale 1ns/1ps
module asb_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 8
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int unsigned CW = $clog2(DEPTH + 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0]    wr_ptr_q;
   logic [PW-1:0]    rd_ptr_q;
   logic [CW-1:0]    count_q;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
      ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + 1'b1;
   endfunction : ptr_inc

   assign in_ready  = (count_q != CW'(DEPTH));
   assign out_valid = (count_q != '0);
   assign out_data  = mem_q[rd_ptr_q];

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_ptr_q] <= in_data;
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         wr_ptr_q <= '0;
         rd_ptr_q <= '0;
         count_q  <= '0;
      end else begin
         if (push) wr_ptr_q <= ptr_inc(wr_ptr_q);
         if (pop)  rd_ptr_q <= ptr_inc(rd_ptr_q);
         count_q <= count_q + CW'(push) - CW'(pop);
      end
   end

endmodule : asb_fifo

// ### testbench/asb_serial_ctrl_sva.sv
/*
 * asb_serial_ctrl_sva: port-level assertions for the serial control block.
 * assumes it is bound to asb_serial_ctrl, with BIT_CYCLES of at least 16.
 */
`timescale 1ns/1ps
module asb_serial_ctrl_sva #(
   parameter int unsigned BIT_CYCLES = 16
) (
   // clock and reset
   input wire logic           clk,
   input wire logic           reset,
   // serial output
   input wire logic           txd_pin,
   // received commands
   input asb_pkg::asb_cmd_t   cmd,
   input wire logic           cmd_valid,
   input wire logic           device_clear,
   // interface state
   input asb_pkg::asb_state_t state,
   input wire logic           remote_indicator_lamp,
   input wire logic           keypad_lockout
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   // length of the current low run on the transmit line
   logic [15:0] low_q;
   wire logic   cmd_open = cmd_valid && !state.locked;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) low_q <= 16'h0000;
      else if (!txd_pin) low_q <= low_q + 16'h0001;
      else low_q <= 16'h0000;
   end

   // a start bit holds the line low for 16 cycles at the bench bit time
   sequence s_start_hold;
      !txd_pin [*8] ##1 !txd_pin [*8];
   endsequence

   property p_frame;
      txd_pin && (low_q != 16'h0000) |-> (low_q % BIT_CYCLES == 0) && (low_q <= 9 * BIT_CYCLES);
   endproperty
   property p_start;
      $fell(txd_pin) |-> s_start_hold;
   endproperty
   property p_ctrl_drop;
      cmd_open |-> (cmd.data >= 8'h20) || (cmd.data == asb_pkg::CODE_LF);
   endproperty
   property p_fold;
      cmd_open |-> !cmd.data[7] && !(cmd.data inside {[8'h61:8'h7A]});
   endproperty
   property p_term;
      cmd_open |-> cmd.term == (cmd.data == asb_pkg::CODE_LF);
   endproperty
   property p_lock_hold;
      state.locked |=> state.locked;
   endproperty
   property p_lock_mode;
      state.locked |-> !state.addressable && !state.listen && !state.talk;
   endproperty
   property p_remote;
      cmd_valid |-> state.remote && (remote_indicator_lamp == keypad_lockout);
   endproperty
   property p_listen_only;
      cmd_valid && state.addressable |-> state.listen;
   endproperty
   property p_one_role;
      state.listen |-> !state.talk;
   endproperty
   property p_clear;
      device_clear |-> state.addressable && !state.listen && !state.talk;
   endproperty

   a_frame: assert property (p_frame) else $error("tx low run not whole bits");
   a_start: assert property (p_start) else $error("start bit too short");
   a_ctrl_drop: assert property (p_ctrl_drop) else $error("control code delivered");
   a_fold: assert property (p_fold) else $error("bit 7 or lower case delivered");
   a_term: assert property (p_term) else $error("terminator flag wrong");
   a_lock_hold: assert property (p_lock_hold) else $error("lock released");
   a_lock_mode: assert property (p_lock_mode) else $error("addressing while locked");
   a_remote: assert property (p_remote) else $error("command without remote");
   a_listen_only: assert property (p_listen_only) else $error("delivery not listening");
   a_one_role: assert property (p_one_role) else $error("listen and talk together");
   a_clear: assert property (p_clear) else $error("clear left addressed");
endmodule : asb_serial_ctrl_sva

// ### testbench/asb_remote_model.sv
/*
 * asb_remote_model: remote controller at the far end of the serial line.
 * assumes the bench clock; sends on its negative edge, samples on the positive.
 */
`timescale 1ns/1ps
module asb_remote_model #(
   parameter int unsigned BIT_CYCLES = 16
) (
   // clock
   input wire logic        clk,
   // serial line
   output logic            rxd_pin,
   input wire logic        txd_pin,
   // received characters
   output logic [7:0]      rx_byte,
   output logic            rx_stb
);
   logic [7:0] got;

   initial begin
      rxd_pin = 1'b1;
      rx_byte = 8'h00;
      rx_stb  = 1'b0;
   end

   // one start, eight data lsb first, one stop, no parity
   task automatic send(input logic [7:0] v);
      logic [9:0] f;
      f = {1'b1, v, 1'b0};
      for (int k = 0; k < 10; k++) begin
         @(negedge clk) rxd_pin = f[k];
         repeat (BIT_CYCLES - 1) @(negedge clk);
      end
   endtask : send

   // receive device frames sampled mid-bit
   always begin
      @(negedge txd_pin);
      repeat (BIT_CYCLES / 2) @(posedge clk);
      for (int k = 0; k < 8; k++) begin
         repeat (BIT_CYCLES) @(posedge clk);
         got[k] = txd_pin;
      end
      repeat (BIT_CYCLES) @(posedge clk);
      if (txd_pin) begin
         rx_byte <= got;
         rx_stb  <= 1'b1;
         @(posedge clk);
         rx_stb  <= 1'b0;
      end
   end
endmodule : asb_remote_model

// ### testbench/asb_serial_ctrl_tb_top.sv
/*
 * asb_serial_ctrl_tb_top: self-checking bench for the serial control block.
 * assumes a short bit time of 16 cycles and the remote model as far end.
 */
`timescale 1ns/1ps
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin err_total++; \
   $display("BAD %0t got %h exp %h", $time, got, exp); end end
module asb_serial_ctrl_tb_top;
   localparam int unsigned BITC = 16;
   logic                clk;
   logic                reset;
   logic                local_key;
   logic                resp_valid;
   logic                resp_ready;
   logic                rxd_pin;
   logic                txd_pin;
   logic                cmd_valid;
   logic                device_clear;
   logic                lamp;
   logic                lockout;
   logic                rx_stb;
   logic [4:0]          own_address;
   logic [4:0]          own;
   logic [4:0]          oth;
   logic [7:0]          resp_data;
   logic [7:0]          rx_byte;
   logic [7:0]          b;
   logic [7:0]          exp_b;
   logic [8:0]          exp_c;
   asb_pkg::asb_cmd_t   cmd;
   asb_pkg::asb_state_t state;
   logic [8:0]          exp_cmd[$];
   logic [7:0]          exp_tx[$];
   logic [7:0]          ccode[4] = '{8'h12, 8'h14, 8'h03, 8'h18};
   int                  err_total, n_compared, n_rx, n_clr, cycles, i, snap;

   asb_serial_ctrl #(
      .BIT_CYCLES (BITC),
      .FIFO_DEPTH (asb_pkg::RESP_FIFO_DEPTH)
   ) uut (
      .clk                   (clk),
      .reset                 (reset),
      .rxd_pin               (rxd_pin),
      .txd_pin               (txd_pin),
      .own_address           (own_address),
      .local_key             (local_key),
      .cmd                   (cmd),
      .cmd_valid             (cmd_valid),
      .device_clear          (device_clear),
      .resp_data             (resp_data),
      .resp_valid            (resp_valid),
      .resp_ready            (resp_ready),
      .state                 (state),
      .remote_indicator_lamp (lamp),
      .keypad_lockout        (lockout)
   );

   asb_remote_model #(.BIT_CYCLES(BITC)) u_host (
      .clk     (clk),
      .rxd_pin (rxd_pin),
      .txd_pin (txd_pin),
      .rx_byte (rx_byte),
      .rx_stb  (rx_stb)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic wrap_up();
      if (exp_cmd.size() != 0 || exp_tx.size() != 0) begin
         err_total++;
         $display("BAD %0t results missing", $time);
      end
      $display("compared %0d mismatches %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : wrap_up

   // result watcher on settled outputs
   always @(negedge clk) begin
      cycles++;
      if (cmd_valid) begin
         if (exp_cmd.size() == 0) begin err_total++; $display("BAD %0t extra command", $time); end
         else begin
            exp_c = exp_cmd.pop_front();
            `CHK(cmd, exp_c)
         end
      end
      if (rx_stb) begin
         n_rx++;
         if (exp_tx.size() == 0) begin err_total++; $display("BAD %0t extra byte", $time); end
         else begin
            exp_b = exp_tx.pop_front();
            `CHK(rx_byte, exp_b)
         end
      end
      if (device_clear) n_clr++;
      if (cycles == 60000) begin err_total++; $display("BAD %0t timeout", $time); wrap_up(); end
   end

   task automatic snd_exp(input logic [7:0] v, input logic [7:0] e);
      exp_cmd.push_back({e, e == 8'h0A});
      u_host.send(v);
   endtask : snd_exp

   task automatic put(input logic [7:0] v);
      logic rdy;
      @(negedge clk) resp_valid = 1'b1;
      resp_data = v;
      for (int k = 0; k < 5000; k++) begin
         rdy = resp_ready;
         @(posedge clk);
         if (rdy) break;
         @(negedge clk);
      end
      @(negedge clk) resp_valid = 1'b0;
   endtask : put

   task automatic drain();
      for (int k = 0; k < 5000 && exp_tx.size() != 0; k++) @(negedge clk);
      repeat (4) @(negedge clk);
   endtask : drain

   task automatic listen_me(input logic [7:0] a);
      exp_tx.push_back(asb_pkg::CODE_ACK);
      u_host.send(8'h12);
      u_host.send(a);
      drain();
   endtask : listen_me

   initial begin
      reset = 1'b1; local_key = 1'b0; resp_valid = 1'b0; resp_data = 8'h00;
      err_total = 0; n_compared = 0; n_rx = 0; n_clr = 0; cycles = 0;
      void'($urandom(86708));
      own = 5'h01 + 5'($urandom % 26);
      oth = own ^ 5'h01;
      own_address = own;
      repeat (2) @(negedge clk);
      reset = 1'b0;
      `CHK(state, 6'h00)
      `CHK({txd_pin, resp_ready, lamp}, 3'b110)
      $display("test reset done");
      snd_exp(8'h61, 8'h41);
      snd_exp(8'hC1, 8'h41);
      u_host.send(8'h0D);
      u_host.send(8'h01);
      u_host.send(8'h12);
      snd_exp(8'h45, 8'h45);
      snd_exp(8'h0A, 8'h0A);
      for (i = 0; i < 3; i++) begin
         b = 8'h21 + 8'($urandom % 90);
         exp_tx.push_back(b);
         put(b);
      end
      drain();
      `CHK(state.addressable, 1'b0)
      $display("test plain done");
      u_host.send(8'h02);
      u_host.send(8'h5A);
      repeat (4) @(negedge clk);
      `CHK(state.addressable, 1'b1)
      listen_me(8'h40 + 8'(own));
      `CHK(state.listen, 1'b1)
      snd_exp(8'h78, 8'h58);
      snd_exp(8'h0A, 8'h0A);
      repeat (4) @(negedge clk);
      `CHK({lamp, lockout}, 2'b11)
      @(negedge clk) local_key = 1'b1;
      @(negedge clk) local_key = 1'b0;
      repeat (3) @(negedge clk);
      `CHK({lamp, lockout}, 2'b00)
      snd_exp(8'h59, 8'h59);
      repeat (4) @(negedge clk);
      `CHK({lamp, lockout}, 2'b11)
      $display("test listen done");
      for (i = 0; i < 4; i++) begin
         listen_me(8'h60 + 8'(own));
         u_host.send(ccode[i]);
         if (i < 2) u_host.send(8'h40 + 8'(oth));
         repeat (4) @(negedge clk);
         `CHK(state.listen, 1'b0)
      end
      `CHK(n_clr, 1)
      @(negedge clk) own_address = 5'h1F;
      listen_me(8'h5F);
      `CHK(state.listen, 1'b1)
      $display("test cancel done");
      for (i = 0; i < 7; i++) begin
         b = 8'h21 + 8'($urandom % 90);
         exp_tx.push_back(b);
         put(b);
      end
      exp_tx.push_back(8'h0A);
      put(8'h0A);
      `CHK(resp_ready, 1'b0)
      u_host.send(8'h14);
      u_host.send(8'h5F);
      repeat (4) @(negedge clk);
      `CHK(state.talk, 1'b1)
      u_host.send(8'h13);
      repeat (4) @(negedge clk);
      snap = n_rx;
      `CHK(state.paused, 1'b1)
      repeat (400) @(negedge clk);
      `CHK(n_rx <= snap + 1, 1'b1)
      u_host.send(8'h11);
      drain();
      `CHK({state.talk, resp_ready}, 2'b01)
      u_host.send(8'h14);
      u_host.send(8'h5F);
      repeat (4) @(negedge clk);
      `CHK(state.talk, 1'b0)
      $display("test talk done");
      u_host.send(8'h04);
      repeat (4) @(negedge clk);
      `CHK({state.locked, state.addressable}, 2'b10)
      snd_exp(8'hE1, 8'hE1);
      snd_exp(8'h61, 8'h61);
      repeat (20) @(negedge clk);
      $display("test lock done");
      wrap_up();
   end
endmodule : asb_serial_ctrl_tb_top

bind asb_serial_ctrl asb_serial_ctrl_sva #(.BIT_CYCLES(BIT_CYCLES)) u_sva (
   .clk                   (clk),
   .reset                 (reset),
   .txd_pin               (txd_pin),
   .cmd                   (cmd),
   .cmd_valid             (cmd_valid),
   .device_clear          (device_clear),
   .state                 (state),
   .remote_indicator_lamp (remote_indicator_lamp),
   .keypad_lockout        (keypad_lockout)
);
